// file: hw/sar_adc_control_sequencer.sv
// Control sequencer for a sign-plus-12-bit successive approximation converter
`timescale 1ns/1ps
module sar_adc_control_sequencer #(
  parameter int BUF_DEPTH = 2
) (
  // Clock, reset, enable
  input  wire logic                      i_ref_clk,
  input  wire logic                      i_nrst,
  input  wire logic                      i_ce,
  // Host control pins
  input  wire logic                      i_chip_sel_n,
  input  wire logic                      i_rd_n,
  input  wire logic                      i_wr_n,
  input  wire logic                      i_cal_n,
  input  wire logic                      i_offset_null_select_n,
  // Host status and result pins
  output logic                           o_eoc,
  output logic                           o_int_n,
  output logic [sar_pkg::RES_W-1:0]      o_result_bus,
  output logic [sar_pkg::RES_W-1:0]      o_result_bus_oe,
  // Analog front end
  input  wire logic                      i_comp_above,
  output logic [sar_pkg::RES_W-1:0]      o_dac_code,
  output logic                           o_sample_en,
  output logic                           o_offset_null_active,
  output logic                           o_cal_offset_phase,
  output logic                           o_cal_ladder_phase,
  output logic                           o_cal_store
);
  logic [1:0]                      rst_pipe_reg;
  logic                            rst_sync_n;
  logic [sar_pkg::PIN_N-1:0]       pin_raw;
  logic [sar_pkg::PIN_N-1:0]       sync1_reg;
  logic [sar_pkg::PIN_N-1:0]       sync2_reg;
  logic [sar_pkg::PIN_N-1:0]       sync3_reg;
  logic [sar_pkg::PIN_N-1:0]       agree;
  logic [sar_pkg::PIN_N-1:0]       pin_f_reg;
  logic [sar_pkg::PIN_N-1:0]       pin_prev_reg;
  logic                            cs_low;
  logic                            read_active;
  logic                            read_prev_reg;
  logic                            read_end;
  logic                            conv_start;
  logic                            cal_start;
  logic                            test_mode;
  logic                            in_cal;
  sar_pkg::seq_state_e             state_reg;
  sar_pkg::seq_state_e             state_next;
  logic [sar_pkg::CNT_W-1:0]       cnt_reg;
  logic [sar_pkg::CNT_W-1:0]       cnt_next;
  logic [sar_pkg::BIT_W-1:0]       bit_reg;
  logic [sar_pkg::BIT_W-1:0]       bit_next;
  logic [sar_pkg::RES_W-1:0]       successive_approx_reg;
  logic [sar_pkg::RES_W-1:0]       sar_next;
  logic                            eoc_reg;
  logic                            int_n_reg;
  logic [sar_pkg::RES_W-1:0]       latch_reg;
  logic                            latch_empty_reg;
  logic                            latch_load;
  logic [sar_pkg::CNT_W-1:0]       cal_len_reg;

  result_buf_if #(.W(sar_pkg::RES_W)) rbuf ();

  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!rst_sync_n || !i_ce);

  function automatic logic is_cal(input sar_pkg::seq_state_e s);
    return (s == sar_pkg::ST_CAL_OFFSET) || (s == sar_pkg::ST_CAL_LADDER)
        || (s == sar_pkg::ST_CAL_STORE);
  endfunction

  function automatic logic is_busy(input sar_pkg::seq_state_e s);
    return is_cal(s) || (s == sar_pkg::ST_SIGN) || (s == sar_pkg::ST_BITS)
        || (s == sar_pkg::ST_STORE);
  endfunction

  // Decide bit k from the comparator and trial-set the bit below it
  function automatic logic [sar_pkg::RES_W-1:0] trial_step(
    input logic [sar_pkg::RES_W-1:0] code,
    input logic [sar_pkg::BIT_W-1:0] k,
    input logic                      keep
  );
    logic [sar_pkg::RES_W-1:0] r;
    r    = code;
    r[k] = keep;
    if (k != sar_pkg::BIT_ZERO)
    begin
      r[k - 1'b1] = 1'b1;
    end
    return r;
  endfunction

  // Reset release through two flops
  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      rst_pipe_reg <= 2'h0;
    end
    else
    begin
      rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
    end
  end
  assign rst_sync_n = rst_pipe_reg[1];

  assign pin_raw = {i_offset_null_select_n, i_cal_n, i_wr_n, i_rd_n, i_chip_sel_n};
  always_ff @(posedge i_ref_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      sync1_reg <= sar_pkg::PIN_IDLE;
      sync2_reg <= sar_pkg::PIN_IDLE;
      sync3_reg <= sar_pkg::PIN_IDLE;
    end
    else if (i_ce)
    begin
      sync1_reg <= pin_raw;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  // accept a change once stages two and three agree
  assign agree = ~(sync2_reg ^ sync3_reg);
  always_ff @(posedge i_ref_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      pin_f_reg     <= sar_pkg::PIN_IDLE;
      pin_prev_reg  <= sar_pkg::PIN_IDLE;
      read_prev_reg <= 1'b0;
    end
    else if (i_ce)
    begin
      pin_f_reg     <= (agree & sync3_reg) | (~agree & pin_f_reg);
      pin_prev_reg  <= pin_f_reg;
      read_prev_reg <= read_active;
    end
  end

  assign cs_low      = !pin_f_reg[sar_pkg::PIN_CS];
  assign read_active = cs_low && !pin_f_reg[sar_pkg::PIN_RD];
  assign read_end    = read_prev_reg && !read_active;
  assign in_cal      = is_cal(state_reg);
  // start on write rising edge; ignored during calibration
  assign conv_start  = pin_f_reg[sar_pkg::PIN_WR] && !pin_prev_reg[sar_pkg::PIN_WR]
                    && cs_low && !in_cal;
  assign cal_start   = !pin_f_reg[sar_pkg::PIN_CAL] && pin_prev_reg[sar_pkg::PIN_CAL]
                    && !in_cal;
  assign test_mode   = cs_low && pin_f_reg[sar_pkg::PIN_RD] && !pin_f_reg[sar_pkg::PIN_CAL];

  always_comb
  begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    bit_next   = bit_reg;
    sar_next   = successive_approx_reg;
    if (cal_start)
    begin
      state_next = sar_pkg::ST_CAL_OFFSET;
      cnt_next   = sar_pkg::CAL_OFFSET_LOAD;
    end
    // a new start abandons any conversion that was running
    else if (conv_start)
    begin
      sar_next = sar_pkg::RES_ZERO;
      // optional offset-null cycle ahead of sampling
      if (!pin_f_reg[sar_pkg::PIN_AZ])
      begin
        state_next = sar_pkg::ST_AUTOZERO;
        cnt_next   = sar_pkg::AZ_LOAD;
      end
      else
      begin
        state_next = sar_pkg::ST_SAMPLE;
        cnt_next   = sar_pkg::SAMPLE_LOAD;
      end
    end
    else
    begin
      case (state_reg)
        sar_pkg::ST_IDLE:
        begin
          state_next = sar_pkg::ST_IDLE;
        end
        // offset phase, then ladder phase, then store
        sar_pkg::ST_CAL_OFFSET:
        begin
          cnt_next = cnt_reg - 1'b1;
          if (cnt_reg == sar_pkg::CNT_ZERO)
          begin
            state_next = sar_pkg::ST_CAL_LADDER;
            cnt_next   = sar_pkg::CAL_LADDER_LOAD;
          end
        end
        sar_pkg::ST_CAL_LADDER:
        begin
          cnt_next = cnt_reg - 1'b1;
          if (cnt_reg == sar_pkg::CNT_ZERO)
          begin
            state_next = sar_pkg::ST_CAL_STORE;
          end
        end
        sar_pkg::ST_CAL_STORE:
        begin
          state_next = sar_pkg::ST_IDLE;
        end
        sar_pkg::ST_AUTOZERO:
        begin
          cnt_next = cnt_reg - 1'b1;
          if (cnt_reg == sar_pkg::CNT_ZERO)
          begin
            state_next = sar_pkg::ST_SAMPLE;
            cnt_next   = sar_pkg::SAMPLE_LOAD;
          end
        end
        // seven cycles after the synchronised edge or after the offset-null cycle; pin jitter
        sar_pkg::ST_SAMPLE:
        begin
          cnt_next = cnt_reg - 1'b1;
          if (cnt_reg == sar_pkg::CNT_ZERO)
          begin
            state_next = sar_pkg::ST_SIGN;
          end
        end
        // compare with ground, sign high for negative
        sar_pkg::ST_SIGN:
        begin
          sar_next   = trial_step(successive_approx_reg, sar_pkg::SIGN_IDX, !i_comp_above);
          bit_next   = sar_pkg::MSB_IDX;
          state_next = sar_pkg::ST_BITS;
        end
        // keep each trial bit only if the input is above
        sar_pkg::ST_BITS:
        begin
          sar_next = trial_step(successive_approx_reg, bit_reg, i_comp_above);
          bit_next = bit_reg - 1'b1;
          if (bit_reg == sar_pkg::BIT_ZERO)
          begin
            state_next = sar_pkg::ST_STORE;
          end
        end
        // hold the result until the buffer accepts it
        sar_pkg::ST_STORE:
        begin
          if (rbuf.push_ready)
          begin
            state_next = sar_pkg::ST_IDLE;
          end
        end
        default:
        begin
          state_next = sar_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // reset lands in the first calibration phase
  always_ff @(posedge i_ref_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      state_reg             <= sar_pkg::ST_CAL_OFFSET;
      cnt_reg               <= sar_pkg::CAL_OFFSET_LOAD;
      bit_reg               <= sar_pkg::MSB_IDX;
      successive_approx_reg <= sar_pkg::RES_ZERO;
    end
    else if (i_ce)
    begin
      state_reg             <= state_next;
      cnt_reg               <= cnt_next;
      bit_reg               <= bit_next;
      successive_approx_reg <= sar_next;
    end
  end

  // end-of-conversion low while calibrating or approximating
  always_ff @(posedge i_ref_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      eoc_reg <= 1'b0;
    end
    else if (i_ce)
    begin
      eoc_reg <= !is_busy(state_next);
    end
  end

  result_buffer #(
    .W     (sar_pkg::RES_W),
    .DEPTH (BUF_DEPTH)
  ) u_result_buffer (
    .i_clk   (i_ref_clk),
    .i_rst_n (rst_sync_n),
    .i_ce    (i_ce),
    .rb      (rbuf)
  );

  assign rbuf.push_valid = (state_reg == sar_pkg::ST_STORE);
  assign rbuf.push_data  = successive_approx_reg;
  assign rbuf.pop_ready  = latch_empty_reg;
  assign latch_load      = rbuf.pop_valid && latch_empty_reg;

  // Output latch refills from the buffer once the host finishes a read
  always_ff @(posedge i_ref_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      latch_reg       <= sar_pkg::RES_ZERO;
      latch_empty_reg <= 1'b1;
    end
    else if (i_ce)
    begin
      if (latch_load)
      begin
        latch_reg       <= rbuf.pop_data;
        latch_empty_reg <= 1'b0;
      end
      else if (read_end)
      begin
        latch_empty_reg <= 1'b1;
      end
    end
  end

  // new result sets interrupt; clears, set wins
  always_ff @(posedge i_ref_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      int_n_reg <= 1'b1;
    end
    else if (i_ce)
    begin
      if (latch_load)
      begin
        int_n_reg <= 1'b0;
      end
      else if (read_active || conv_start || cal_start)
      begin
        int_n_reg <= 1'b1;
      end
    end
  end

  // Calibration length monitor
  always_ff @(posedge i_ref_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      cal_len_reg <= sar_pkg::CNT_ZERO;
    end
    else if (i_ce)
    begin
      cal_len_reg <= in_cal ? cal_len_reg + 1'b1 : sar_pkg::CNT_ZERO;
    end
  end

  // two's complement word straight from the latch
  assign o_result_bus = latch_reg;
  // read drives all bits; test mode drives four bits
  assign o_result_bus_oe = read_active ? sar_pkg::RES_ALL
                         : test_mode   ? sar_pkg::TEST_OE_MASK
                         : sar_pkg::RES_ZERO;
  assign o_eoc                = eoc_reg;
  assign o_int_n              = int_n_reg;
  assign o_dac_code           = successive_approx_reg;
  assign o_sample_en          = (state_reg == sar_pkg::ST_SAMPLE);
  assign o_offset_null_active = (state_reg == sar_pkg::ST_AUTOZERO);
  assign o_cal_offset_phase   = (state_reg == sar_pkg::ST_CAL_OFFSET);
  assign o_cal_ladder_phase   = (state_reg == sar_pkg::ST_CAL_LADDER);
  assign o_cal_store          = (state_reg == sar_pkg::ST_CAL_STORE);

  cs_gates_bus_a: assert property (
    !cs_low |-> (o_result_bus_oe == sar_pkg::RES_ZERO))
    else $error("bus driven with chip select high");
  read_drive_a: assert property (
    read_active && !latch_load |-> (o_result_bus_oe == sar_pkg::RES_ALL) ##1 o_int_n)
    else $error("read did not drive bus or clear interrupt");
  start_int_clear_a: assert property (
    conv_start && !latch_load |=> o_int_n)
    else $error("start did not clear interrupt");
  cal_phase_eoc_a: assert property (
    in_cal |-> !o_eoc)
    else $error("end-of-conversion high during calibration");
  cal_length_a: assert property (
    (state_reg == sar_pkg::ST_CAL_STORE) |-> (cal_len_reg == 11'(sar_pkg::CAL_CYC - 1)))
    else $error("calibration length wrong");
  cal_ignores_start_a: assert property (
    in_cal && !o_cal_store |=> in_cal)
    else $error("calibration interrupted");
  sample_length_a: assert property (
    (state_reg == sar_pkg::ST_SIGN) |-> $past(o_sample_en) && $past(o_sample_en, 7)
      && !o_eoc)
    else $error("sampling too short or end-of-conversion high");
  az_length_a: assert property (
    o_sample_en && $past(o_offset_null_active) && !$past(conv_start)
      |-> $past(o_offset_null_active, 26))
    else $error("offset-null cycle too short");
  result_int_a: assert property (
    latch_load |=> !o_int_n && (o_result_bus == $past(rbuf.pop_data)))
    else $error("new result did not set interrupt");
  sign_decide_a: assert property (
    (state_reg == sar_pkg::ST_SIGN) && !conv_start && !cal_start
      |=> (o_dac_code[sar_pkg::SIGN_BIT] == !$past(i_comp_above)))
    else $error("sign bit wrong");
endmodule

// file: common/sar_pkg.sv
// Shared constants and types for the converter control sequencer
package sar_pkg;
  localparam int RES_W    = 13;
  localparam int SIGN_BIT = 12;
  localparam int MSB_BIT  = 11;
  localparam int CNT_W    = 11;
  localparam int BIT_W    = 4;

  // Durations in clock periods of the 10 MHz reference clock
  localparam int CAL_PERIODS        = 1396;
  localparam int CAL_OFFSET_PERIODS = 64;
  localparam int AZ_PERIODS         = 26;
  localparam int SAMPLE_PERIODS     = 7;
  localparam int CYC_PER_PERIOD     = 1;
  localparam int CAL_CYC            = CAL_PERIODS * CYC_PER_PERIOD;
  localparam int CAL_OFFSET_CYC     = CAL_OFFSET_PERIODS * CYC_PER_PERIOD;
  localparam int AZ_CYC             = AZ_PERIODS * CYC_PER_PERIOD;
  localparam int SAMPLE_CYC         = SAMPLE_PERIODS * CYC_PER_PERIOD;

  // Down-counter loads; the last calibration cycle is the store cycle
  localparam logic [CNT_W-1:0] CAL_OFFSET_LOAD = CNT_W'(CAL_OFFSET_CYC - 1);
  localparam logic [CNT_W-1:0] CAL_LADDER_LOAD = CNT_W'(CAL_CYC - CAL_OFFSET_CYC - 2);
  localparam logic [CNT_W-1:0] AZ_LOAD         = CNT_W'(AZ_CYC - 1);
  localparam logic [CNT_W-1:0] SAMPLE_LOAD     = CNT_W'(SAMPLE_CYC - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO        = 11'h000;
  localparam logic [BIT_W-1:0] SIGN_IDX        = BIT_W'(SIGN_BIT);
  localparam logic [BIT_W-1:0] MSB_IDX         = BIT_W'(MSB_BIT);
  localparam logic [BIT_W-1:0] BIT_ZERO        = 4'h0;

  // Synchroniser vector positions and idle level of the host pins
  localparam int PIN_CS  = 0;
  localparam int PIN_RD  = 1;
  localparam int PIN_WR  = 2;
  localparam int PIN_CAL = 3;
  localparam int PIN_AZ  = 4;
  localparam int PIN_N   = 5;
  localparam logic [PIN_N-1:0] PIN_IDLE = 5'h1F;

  localparam logic [RES_W-1:0] RES_ZERO     = 13'h0000;
  localparam logic [RES_W-1:0] RES_ALL      = 13'h1FFF;
  localparam logic [RES_W-1:0] TEST_OE_MASK = 13'h006C;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_CAL_OFFSET,
    ST_CAL_LADDER,
    ST_CAL_STORE,
    ST_AUTOZERO,
    ST_SAMPLE,
    ST_SIGN,
    ST_BITS,
    ST_STORE
  } seq_state_e;
endpackage

// file: common/result_buf_if.sv
// Push and pop handshake between the sequencer and its result buffer
`timescale 1ns/1ps
interface result_buf_if #(
  parameter int W = sar_pkg::RES_W
);
  logic         push_valid;
  logic         push_ready;
  logic [W-1:0] push_data;
  logic         pop_valid;
  logic         pop_ready;
  logic [W-1:0] pop_data;

  modport store (
    input  push_valid,
    input  push_data,
    input  pop_ready,
    output push_ready,
    output pop_valid,
    output pop_data
  );
  modport user (
    output push_valid,
    output push_data,
    output pop_ready,
    input  push_ready,
    input  pop_valid,
    input  pop_data
  );
endinterface

// file: hw/result_buffer.sv
// Small ring buffer for finished conversion results
`timescale 1ns/1ps
module result_buffer #(
  parameter int W     = sar_pkg::RES_W,
  parameter int DEPTH = 2
) (
  // Clock, reset, enable
  input  wire logic   i_clk,
  input  wire logic   i_rst_n,
  input  wire logic   i_ce,
  // Push and pop sides
  result_buf_if.store rb
);
  localparam int              AW   = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0]     FULL = (AW + 1)'(DEPTH);
  localparam logic [AW-1:0]   LAST = AW'(DEPTH - 1);

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0]   count_reg;
  logic          push;
  logic          pop;

  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    return (p == LAST) ? '0 : p + 1'b1;
  endfunction

  assign rb.push_ready = (count_reg != FULL);
  assign rb.pop_valid  = (count_reg != '0);
  assign rb.pop_data   = mem[rd_ptr_reg];
  assign push          = rb.push_valid && rb.push_ready;
  assign pop           = rb.pop_valid && rb.pop_ready;

  always_ff @(posedge i_clk)
  begin
    if (i_ce && push)
    begin
      mem[wr_ptr_reg] <= rb.push_data;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end
    else if (i_ce)
    begin
      if (push)
      begin
        wr_ptr_reg <= ptr_inc(wr_ptr_reg);
      end
      if (pop)
      begin
        rd_ptr_reg <= ptr_inc(rd_ptr_reg);
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      count_reg <= '0;
    end
    else if (i_ce)
    begin
      case ({push, pop})
        2'b10:   count_reg <= count_reg + 1'b1;
        2'b01:   count_reg <= count_reg - 1'b1;
        default: count_reg <= count_reg;
      endcase
    end
  end
endmodule

// file: bench/comparator_model.sv
// Comparator model answering the sequencer's trial codes
`timescale 1ns/1ps
module comparator_model (
  // Held input level and trial code
  input  wire logic [sar_pkg::RES_W-1:0] i_level,
  input  wire logic [sar_pkg::RES_W-1:0] i_dac_code,
  // Comparison result
  output logic                           o_comp_above
);
  // Ties count as above, a half-step offset so each level maps to its own code
  assign o_comp_above = $signed(i_level) >= $signed(i_dac_code);
endmodule

// file: bench/tb_sar_adc_control_sequencer.sv
// Self-checking bench for the converter control sequencer
`timescale 1ns/1ps
module tb_sar_adc_control_sequencer;
  logic                      ref_clk = 1'b0;
  logic                      nrst, cs_n, rd_n, wr_n, cal_n, az_n, comp_above;
  logic                      eoc, int_n, sample_en;
  logic [sar_pkg::RES_W-1:0] bus, oe, dac, level;
  int                        errors = 0;
  int                        tests_run = 0;
  int                        samp_cnt, n, i;
  int                        low_cnt, off_cnt, lad_cnt, st_cnt, az_cnt;
  logic                      off_ph, lad_ph, cal_st, az_act;
  int                        lat [2];
  logic [sar_pkg::RES_W-1:0] vals [4] = '{13'h0123, 13'h1F00, 13'h0FFF, 13'h1000};

  always #50 ref_clk = ~ref_clk;
  // Phase length counters, sampled before each edge updates the outputs
  always @(posedge ref_clk)
  begin
    samp_cnt <= samp_cnt + (sample_en === 1'b1);
    az_cnt   <= az_cnt + (az_act === 1'b1);
    low_cnt  <= low_cnt + (eoc === 1'b0);
    off_cnt  <= off_cnt + (off_ph === 1'b1);
    lad_cnt  <= lad_cnt + (lad_ph === 1'b1);
    st_cnt   <= st_cnt + (cal_st === 1'b1);
  end

  sar_adc_control_sequencer i_sar_adc_control_sequencer (
    .i_ref_clk(ref_clk), .i_nrst(nrst), .i_ce(1'b1), .i_chip_sel_n(cs_n),
    .i_rd_n(rd_n), .i_wr_n(wr_n), .i_cal_n(cal_n), .i_offset_null_select_n(az_n),
    .o_eoc(eoc), .o_int_n(int_n), .o_result_bus(bus), .o_result_bus_oe(oe),
    .i_comp_above(comp_above), .o_dac_code(dac), .o_sample_en(sample_en),
    .o_offset_null_active(az_act), .o_cal_offset_phase(off_ph),
    .o_cal_ladder_phase(lad_ph), .o_cal_store(cal_st)
  );
  comparator_model i_comparator_model (
    .i_level(level), .i_dac_code(dac), .o_comp_above(comp_above)
  );

  task automatic cyc(input int k);
    repeat (k) @(negedge ref_clk);
  endtask

  task automatic check(input logic [12:0] seen, input logic [12:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      errors++;
      $display("BAD %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wait_eoc(input logic lvl, output int k);
    k = 0;
    while (eoc !== lvl && k < 3000)
    begin
      cyc(1);
      k++;
    end
  endtask

  task automatic start(input logic az);
    az_n = az;
    cs_n = 1'b0;
    wr_n = 1'b0;
    cyc(5);
    wr_n = 1'b1;
    cyc(5);
    cs_n = 1'b1;
  endtask

  task automatic read_word(input logic [12:0] exp);
    cs_n = 1'b0;
    rd_n = 1'b0;
    cyc(6);
    check(oe, 13'h1FFF);
    check(bus, exp);
    check({12'h000, int_n}, 13'h0001);
    rd_n = 1'b1;
    cs_n = 1'b1;
    cyc(6);
    check(oe, 13'h0000);
  endtask

  task automatic t_cal(input logic poke);
    low_cnt = 0;
    off_cnt = 0;
    lad_cnt = 0;
    st_cnt = 0;
    cal_n = 1'b0;
    cyc(6);
    // request back high before any start
    cal_n = 1'b1;
    wait_eoc(1'b0, n);
    check({12'h000, int_n}, 13'h0001);
    if (poke)
      start(1'b1);
    wait_eoc(1'b1, n);
    check(13'(low_cnt), 13'h0574);
    check(13'(off_cnt), 13'h0040);
    check(13'(lad_cnt), 13'h0533);
    check(13'(st_cnt), 13'h0001);
  endtask

  task automatic t_convert;
    for (i = 0; i < 4; i++)
    begin
      level = vals[i];
      samp_cnt = 0;
      az_cnt = 0;
      start(i[0]);
      wait_eoc(1'b0, lat[i[0]]);
      wait_eoc(1'b1, n);
      check(13'(n), 13'h000E);
      check(13'(samp_cnt), 13'h0007);
      check(13'(az_cnt), i[0] ? 13'h0000 : 13'h001A);
      cyc(3);
      check({12'h000, int_n}, 13'h0000);
      read_word(vals[i]);
    end
    check(13'(lat[0] - lat[1]), 13'h001A);
  endtask

  task automatic t_queue;
    level = 13'h0055;
    start(1'b1);
    wait_eoc(1'b0, n);
    wait_eoc(1'b1, n);
    cyc(3);
    check({12'h000, int_n}, 13'h0000);
    level = 13'h1ABC;
    start(1'b1);
    check({12'h000, int_n}, 13'h0001);
    wait_eoc(1'b0, n);
    wait_eoc(1'b1, n);
    level = 13'h0777;
    start(1'b1);
    cyc(2);
    level = 13'h0A0A;
    start(1'b1);
    wait_eoc(1'b0, n);
    wait_eoc(1'b1, n);
    t_cal(1'b0);
    level = 13'h1001;
    start(1'b1);
    cyc(40);
    check({12'h000, eoc}, 13'h0000);
    read_word(13'h0055);
    read_word(13'h1ABC);
    read_word(13'h0A0A);
    read_word(13'h1001);
    cyc(20);
    check({12'h000, int_n}, 13'h0001);
  endtask

  task automatic t_misc;
    wr_n = 1'b0;
    cyc(5);
    wr_n = 1'b1;
    cyc(40);
    check({12'h000, eoc}, 13'h0001);
    rd_n = 1'b0;
    cyc(6);
    check(oe, 13'h0000);
    rd_n = 1'b1;
    cs_n = 1'b0;
    cal_n = 1'b0;
    cyc(6);
    check(oe, 13'h006C);
    cal_n = 1'b1;
    cs_n = 1'b1;
    wait_eoc(1'b1, n);
    level = 13'h0001;
    start(1'b0);
    wait_eoc(1'b0, n);
    wait_eoc(1'b1, n);
    cyc(3);
    t_cal(1'b1);
  endtask

  task automatic stop_test;
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial
  begin
    {nrst, cs_n, rd_n, wr_n, cal_n, az_n} = 6'h1F;
    level = 13'h0000;
    samp_cnt = 0;
    cyc(16);
    nrst = 1'b1;
    wait_eoc(1'b1, n);
    t_cal(1'b0);
    t_convert;
    t_queue;
    t_misc;
    stop_test;
  end

  initial
  begin
    cyc(60000);
    errors++;
    stop_test;
  end
endmodule
